// ---- shared/slfp_defs.svh ----
// Offsets, field positions, reset values and counts of the serial lane frame packer.
// Assumes it is included by bare name from the package and the packer module.
`ifndef SLFP_DEFS_SVH
`define SLFP_DEFS_SVH

// Register offsets on the plain register port
`define SLFP_REG_CFG       8'h00
`define SLFP_REG_MODE      8'h01
`define SLFP_REG_ALIGN0    8'h02
`define SLFP_REG_ALIGN1    8'h03
`define SLFP_REG_ALIGN2    8'h04
`define SLFP_REG_ALIGN3    8'h05
`define SLFP_REG_STATUS    8'h06

// Fields of serial_frame_config
`define SLFP_CFG_TOGGLE    0
`define SLFP_CFG_BAL_ENA   1
`define SLFP_CFG_BAL_SEL   2
`define SLFP_CFG_LSB_FIRST 3
`define SLFP_CFG_COMPACT   4
`define SLFP_CFG_RST       5'h0F

// Fields of the mode register
`define SLFP_MODE_DDC      0
`define SLFP_MODE_DEC_LSB  1
`define SLFP_MODE_CH_LSB   4
`define SLFP_MODE_FINE     6
`define SLFP_MODE_RST      7'h00
`define SLFP_DEC_64        3'h5

// Default alignment pattern and synchronisation counts
`define SLFP_ALIGN_RST     64'hACF0_FF00_FFFF_0000
`define SLFP_SEQ_FRAMES    32
`define SLFP_LFSR_SEED     31'h0000_0ACE
`define SLFP_REAL_LANES    10
`define SLFP_DISP_LIMIT    64

`endif

// ---- shared/slfp_pkg.sv ----
// Types shared by the serial lane frame packer and its users.
// Assumes the constants header sits beside it on the include path.
package slfp_pkg;
    `include "slfp_defs.svh"

    // Kind of frame being sent on every lane
    typedef enum logic [1:0] {SEQ_DATA, SEQ_ALIGN, SEQ_PRBS} slfp_seq_t;

    // Content of a fine-channel frame at high decimation
    typedef enum logic [1:0] {FS_EMPTY, FS_CH12, FS_CH34} slfp_fstate_t;

    // One I/Q pair, I in the low bits so it is sent first
    typedef struct packed {
        logic [14:0] q;
        logic [14:0] i;
    } slfp_iq_t;

    // Samples offered for one frame slot on all lanes
    typedef struct packed {
        logic                   valid;
        slfp_fstate_t           fstate;
        logic [59:0][9:0]       real_smp;
        slfp_iq_t [15:0]        iq;
    } slfp_smp_t;

    // Plain register port request
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [7:0]             addr;
        logic [15:0]            wdata;
    } slfp_regbus_t;

    // One 64-bit frame per lane
    typedef logic [10:0][63:0] slfp_lanes_t;
endpackage : slfp_pkg

// ---- logic/slfp_frame_packer.sv ----
// Serial lane frame packer: builds one 64-bit frame per lane per clock.
// Assumes samples arrive on sys_clk; sync_req is an asynchronous pin.
`timescale 1ns/10ps
`include "slfp_defs.svh"

module slfp_frame_packer #(
    parameter int unsigned SEQ_FRAMES = `SLFP_SEQ_FRAMES,
    parameter logic [30:0] LFSR_SEED  = `SLFP_LFSR_SEED
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire slfp_pkg::slfp_regbus_t bus_in,
    output      logic [15:0]            reg_rdata_ff,
    input  wire logic                   sync_req,
    input  wire slfp_pkg::slfp_smp_t    smp_in,
    output      slfp_pkg::slfp_lanes_t  lane_frame_ff,
    output      slfp_pkg::slfp_seq_t    frame_kind_ff
);
    import slfp_pkg::*;

    localparam int LANES = 11;

    // Refuse settings the logic cannot serve
    initial begin
        if (SEQ_FRAMES < 1 || SEQ_FRAMES > 64) $error("SEQ_FRAMES out of range");
        if (LFSR_SEED[19:0] == 20'h0_0000) $error("LFSR_SEED low bits must be nonzero");
    end

    // Per-lane scrambler start value, kept distinct per lane
    function automatic logic [30:0] lane_seed(input int k);
        lane_seed = LFSR_SEED ^ (31'(k) << 20);
    endfunction : lane_seed

    // Advance the x31+x28+1 generator by 62 bits
    function automatic logic [92:0] prbs_step(input logic [30:0] s);
        logic [30:0] st;
        logic [61:0] bits;
        st = s;
        bits = '0;
        for (int n = 0; n < 62; n++) begin
            bits[n] = st[30];
            st = {st[29:0], st[30] ^ st[27]};
        end
        prbs_step = {st, bits};
    endfunction : prbs_step

    // Disparity of a frame: ones minus zeros
    function automatic logic signed [9:0] frame_disp(input logic [63:0] f);
        logic [6:0] ones;
        ones = '0;
        for (int n = 0; n < 64; n++) ones = ones + 7'(f[n]);
        frame_disp = $signed({2'b00, ones, 1'b0}) - 10'sd64;
    endfunction : frame_disp

    // Number of lanes that carry samples in the current mode
    function automatic logic [3:0] lane_count(input logic ddc, input logic [2:0] dec,
                                              input logic fine, input logic [1:0] ch);
        logic [3:0] nch;
        nch = 4'(1) << ch;
        if (!ddc) lane_count = 4'(`SLFP_REAL_LANES);
        else if (dec < 3'h3 || (dec == 3'h3 && !fine)) lane_count = 4'h8 >> dec;
        else if (dec == 3'h3) lane_count = nch;
        else if (dec == 3'h4) lane_count = (nch == 4'h4) ? 4'h2 : 4'h1;
        else lane_count = 4'h1;
    endfunction : lane_count

    // Software visible settings
    logic [4:0]              cfg_ff;        // serial_frame_config
    logic [6:0]              mode_ff;       // Down-converter mode
    logic [63:0]             align_ff;      // alignment_pattern_word
    // Synchroniser and sequence state
    logic                    sync_m_ff;     // First sync stage
    logic                    sync_s_ff;     // Second sync stage
    logic                    sync_d_ff;     // Edge detect delay
    logic                    sync_evt;      // Request accepted
    slfp_seq_t               seq_ff;        // Frame kind now built
    slfp_seq_t               nxt_seq;
    logic [5:0]              cnt_ff;        // Frames sent in sequence
    logic [5:0]              nxt_cnt;
    // Per-lane state
    logic [LANES-1:0][30:0]  lfsr_ff;       // Scrambler state
    logic [LANES-1:0][30:0]  nxt_lfsr;
    logic [LANES-1:0]        tog_run_ff;    // Running toggle, held during pattern frames
    // Running disparity wraps if balance stays off for a long time
    logic signed [9:0]       rd_ff   [LANES];
    logic signed [9:0]       nxt_rd  [LANES];
    slfp_lanes_t             nxt_frame;
    slfp_lanes_t             raw_frame;     // Frame before scrambling
    logic [LANES-1:0]        bal_flag;      // Inversion decided

    // Decoded mode and serial_frame_config fields
    logic                    ddc_on;
    logic [2:0]              dec_code;
    logic [1:0]              ch_code;
    logic [3:0]              n_lanes;
    logic                    fine_hi;
    logic                    compact;
    logic                    bal_on;

    assign ddc_on   = mode_ff[`SLFP_MODE_DDC];
    assign dec_code = mode_ff[`SLFP_MODE_DEC_LSB +: 3];
    assign ch_code  = mode_ff[`SLFP_MODE_CH_LSB +: 2];
    assign n_lanes  = lane_count(ddc_on, dec_code, mode_ff[`SLFP_MODE_FINE], ch_code);
    assign fine_hi  = ddc_on && dec_code >= `SLFP_DEC_64;
    assign compact  = cfg_ff[`SLFP_CFG_COMPACT] && dec_code == `SLFP_DEC_64;
    assign bal_on   = cfg_ff[`SLFP_CFG_BAL_ENA] && cfg_ff[`SLFP_CFG_BAL_SEL];

    // Register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff   <= `SLFP_CFG_RST;
            mode_ff  <= `SLFP_MODE_RST;
            align_ff <= `SLFP_ALIGN_RST;
        end else if (bus_in.wr) begin
            unique case (bus_in.addr)
                `SLFP_REG_CFG:    cfg_ff  <= bus_in.wdata[4:0];
                `SLFP_REG_MODE:   mode_ff <= bus_in.wdata[6:0];
                `SLFP_REG_ALIGN0: align_ff[15:0]  <= bus_in.wdata;
                `SLFP_REG_ALIGN1: align_ff[31:16] <= bus_in.wdata;
                `SLFP_REG_ALIGN2: align_ff[47:32] <= bus_in.wdata;
                `SLFP_REG_ALIGN3: align_ff[63:48] <= bus_in.wdata;
                default: ;                                   // Unmapped write ignored
            endcase
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 16'h0000;
        end else if (bus_in.rd) begin
            unique case (bus_in.addr)
                `SLFP_REG_CFG:    reg_rdata_ff <= {11'h000, cfg_ff};
                `SLFP_REG_MODE:   reg_rdata_ff <= {9'h000, mode_ff};
                `SLFP_REG_ALIGN0: reg_rdata_ff <= align_ff[15:0];
                `SLFP_REG_ALIGN1: reg_rdata_ff <= align_ff[31:16];
                `SLFP_REG_ALIGN2: reg_rdata_ff <= align_ff[47:32];
                `SLFP_REG_ALIGN3: reg_rdata_ff <= align_ff[63:48];
                `SLFP_REG_STATUS: reg_rdata_ff <= {8'h00, cnt_ff, seq_ff};
                default:          reg_rdata_ff <= 16'h0000;  // Unmapped reads zero
            endcase
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end

    // Two-stage synchroniser and rising edge of the request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_m_ff <= 1'b0;
            sync_s_ff <= 1'b0;
            sync_d_ff <= 1'b0;
        end else begin
            sync_m_ff <= sync_req;
            sync_s_ff <= sync_m_ff;
            sync_d_ff <= sync_s_ff;
        end
    end
    // Requests during a running sequence are ignored
    assign sync_evt = sync_s_ff && !sync_d_ff && seq_ff == SEQ_DATA;

    // Sequence control: pattern frames, then PRBS frames, then data
    always_comb begin
        nxt_seq = seq_ff;
        nxt_cnt = cnt_ff + 6'h01;
        unique case (seq_ff)
            SEQ_DATA: begin
                nxt_cnt = 6'h00;
                if (sync_evt) nxt_seq = SEQ_ALIGN;
            end
            SEQ_ALIGN: begin
                if (cnt_ff == 6'(SEQ_FRAMES - 1)) begin
                    nxt_seq = SEQ_PRBS;
                    nxt_cnt = 6'h00;
                end
            end
            SEQ_PRBS: begin
                if (cnt_ff == 6'(SEQ_FRAMES - 1)) begin
                    nxt_seq = SEQ_DATA;
                    nxt_cnt = 6'h00;
                end
            end
            default: begin                                   // Illegal code recovers
                nxt_seq = SEQ_DATA;
                nxt_cnt = 6'h00;
            end
        endcase
    end

    // Sequence state registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_ff <= SEQ_DATA;
            cnt_ff <= 6'h00;
        end else begin
            seq_ff <= nxt_seq;
            cnt_ff <= nxt_cnt;
        end
    end

    // Per-lane frame assembly, scrambling and balance
    always_comb begin
        logic [59:0]       pl;
        logic              used;
        logic              full;
        logic              tog;
        logic              cb1;
        logic [92:0]       step;
        logic [63:0]       pre;
        logic [63:0]       fin;
        logic signed [9:0] sum;
        // Defaults so that no lane variable holds a stale value
        pl   = '0;
        used = 1'b0;
        full = 1'b0;
        tog  = 1'b0;
        cb1  = 1'b0;
        step = '0;
        pre  = '0;
        fin  = '0;
        sum  = '0;
        for (int k = 0; k < LANES; k++) begin
            pl   = '0;
            step = prbs_step(lfsr_ff[k]);
            used = ddc_on ? (4'(k) < n_lanes) : (k < `SLFP_REAL_LANES);
            full = smp_in.valid && used && !(fine_hi && smp_in.fstate == FS_EMPTY);
            if (full && !ddc_on) begin
                pl = smp_in.real_smp[k*6 +: 6];
            end else if (full) begin
                pl = {smp_in.iq[(k + int'(n_lanes)) % 16], smp_in.iq[k]};
            end
            tog = cfg_ff[`SLFP_CFG_TOGGLE] ? tog_run_ff[k] : 1'b1;
            if (fine_hi && compact) begin
                tog = (ch_code == 2'h2) ? (smp_in.fstate == FS_CH12) : full;
            end else if (fine_hi && smp_in.fstate != FS_EMPTY) begin
                tog = (smp_in.fstate == FS_CH12);
            end
            cb1 = ^pl;
            raw_frame[k] = {pl[59:30], full, cb1, pl[29:0], tog, 1'b0};
            pre = {raw_frame[k][63:2] ^ step[61:0], tog, 1'b0};
            if (seq_ff == SEQ_PRBS) pre = {step[61:0], tog, 1'b0};
            sum = rd_ff[k] + frame_disp(pre);
            bal_flag[k] = bal_on && (sum > 10'sd64 || sum < -10'sd64);
            fin = bal_flag[k] ? {~pre[63:1], 1'b1} : pre;
            nxt_rd[k] = rd_ff[k] + frame_disp(fin);
            nxt_lfsr[k] = step[92:62];
            if (seq_ff == SEQ_ALIGN) begin
                fin = cfg_ff[`SLFP_CFG_LSB_FIRST] ? align_ff : {<<{align_ff}};
                nxt_rd[k] = rd_ff[k];
                nxt_lfsr[k] = lfsr_ff[k];
            end
            if (sync_evt) nxt_lfsr[k] = lane_seed(k);
            nxt_frame[k] = fin;
        end
    end

    // Per-lane running state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < LANES; k++) begin
                lfsr_ff[k] <= lane_seed(k);
                rd_ff[k]   <= 10'sd0;
            end
            tog_run_ff <= '0;
        end else begin
            for (int k = 0; k < LANES; k++) begin
                lfsr_ff[k] <= nxt_lfsr[k];
                rd_ff[k]   <= nxt_rd[k];
                if (seq_ff != SEQ_ALIGN) tog_run_ff[k] <= ~tog_run_ff[k];
            end
        end
    end

    // Frame outputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lane_frame_ff <= '0;
            frame_kind_ff <= SEQ_DATA;
        end else begin
            lane_frame_ff <= nxt_frame;
            frame_kind_ff <= seq_ff;
        end
    end

    // Checks on the frame logic
    default clocking dflt_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Sequence length as an int for the cycle delays below
    localparam int SEQ_LEN = SEQ_FRAMES;
    // Scrambler bits of lane 0 this frame, for the balance check
    logic [92:0]             scr_step0;
    assign scr_step0 = prbs_step(lfsr_ff[0]);

    a_align_length: assert property ($rose(seq_ff == SEQ_ALIGN) |-> ##SEQ_LEN seq_ff == SEQ_PRBS)
        else $error("pattern phase length wrong");
    a_prbs_length: assert property ($rose(seq_ff == SEQ_PRBS) |-> ##SEQ_LEN seq_ff == SEQ_DATA)
        else $error("prbs phase length wrong");
    a_align_word: assert property (frame_kind_ff == SEQ_ALIGN && $past(cfg_ff[3])
        |-> lane_frame_ff[0] == $past(align_ff))
        else $error("pattern frame differs from pattern");
    a_toggle_flips: assert property (cfg_ff[`SLFP_CFG_TOGGLE] && $past(cfg_ff[`SLFP_CFG_TOGGLE])
        && $past(rst_n) && $past(seq_ff) != SEQ_ALIGN && !fine_hi && !$past(fine_hi)
        |-> raw_frame[3][1] != $past(raw_frame[3][1]))
        else $error("toggle bit did not flip");
    a_balance_flag: assert property (seq_ff == SEQ_DATA && bal_flag[0]
        |=> lane_frame_ff[0][0] && lane_frame_ff[0][1] == ~$past(raw_frame[0][1])
            && lane_frame_ff[0][63:2] == ~($past(raw_frame[0][63:2]) ^ $past(scr_step0[61:0])))
        else $error("balance flag not sent");
    a_balance_off: assert property (!bal_on && seq_ff != SEQ_ALIGN |=> lane_frame_ff[5][0] == 1'b0)
        else $error("balance bit set while disabled");
    a_empty_cb2: assert property (!smp_in.valid |-> raw_frame[2][33] == 1'b0 && raw_frame[2][63:34] == '0)
        else $error("empty frame marked full");
    a_parity_even: assert property (^{raw_frame[1][63:34], raw_frame[1][32], raw_frame[1][31:2]} == 1'b0)
        else $error("payload parity wrong");
    a_lane_ten: assert property (!ddc_on |-> raw_frame[10][63:34] == '0 && raw_frame[10][31:2] == '0)
        else $error("eleventh lane carries payload");
    a_scram_reset: assert property (sync_evt |=> lfsr_ff[4] == lane_seed(4) ##SEQ_LEN lfsr_ff[4] == lane_seed(4))
        else $error("scrambler not reset on sync");
    a_fine_pair: assert property (fine_hi && !compact && smp_in.fstate == FS_CH34 && smp_in.valid
        |-> raw_frame[0][1] == 1'b0 && raw_frame[0][33])
        else $error("channel pair coding wrong");
endmodule : slfp_frame_packer

// ---- bench/slfp_lane_receiver.sv ----
// Receiver model on the far side of the lanes: undoes balance inversion, watches the toggle bit.
// Assumes lane frames change just after rising sys_clk edges.
`timescale 1ns/10ps

module slfp_lane_receiver (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire slfp_pkg::slfp_lanes_t lane_frame,
    input  wire slfp_pkg::slfp_seq_t   frame_kind,
    input  wire logic                  toggle_on,
    output      slfp_pkg::slfp_lanes_t rx_lanes,
    output      logic [15:0]           toggle_errs_ff
);
    import slfp_pkg::*;

    logic prev_ok_ff;   // Last frame was data with toggle watched
    logic prev_bit_ff;  // Toggle seen on lane 0 last frame

    // Re-invert bits 63:1 when the balance flag is set
    always_comb begin
        for (int k = 0; k < 11; k++) begin
            rx_lanes[k] = lane_frame[k][0] ? {~lane_frame[k][63:1], 1'b1} : lane_frame[k];
        end
    end

    // Toggle must flip between successive data frames
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ok_ff     <= 1'b0;
            prev_bit_ff    <= 1'b0;
            toggle_errs_ff <= 16'h0000;
        end else begin
            prev_ok_ff  <= toggle_on && (frame_kind == SEQ_DATA);
            prev_bit_ff <= rx_lanes[0][1];
            if (prev_ok_ff && toggle_on && frame_kind == SEQ_DATA && rx_lanes[0][1] == prev_bit_ff) begin
                toggle_errs_ff <= toggle_errs_ff + 16'h0001;
            end
        end
    end
endmodule : slfp_lane_receiver

// ---- bench/slfp_frame_packer_bench.sv ----
// Self-checking bench of the frame packer: registers, sync sequence, packing by XOR against a zero run.
// Assumes the package and constants header are compiled first.
`timescale 1ns/10ps
`include "slfp_defs.svh"

module slfp_frame_packer_bench;
    import slfp_pkg::*;

    localparam int SEQ_N = 4;            // Shortened sequence length
    logic          sys_clk = 1'b0;       // 100 MHz clock
    logic          rst_n   = 1'b0;       // Active low reset
    slfp_regbus_t  bus     = '0;         // Register port request
    logic          sync_req = 1'b0;      // Sync pin
    slfp_smp_t     smp_in  = '0;         // Sample slot
    logic [15:0]   rdata;                // Read data
    slfp_lanes_t   lanes;                // Raw frames
    slfp_lanes_t   rx_lanes;             // Decoded frames
    slfp_seq_t     kind;                 // Frame kind
    logic          toggle_on = 1'b0;     // Receiver watches toggle
    logic [15:0]   tgl_errs;             // Toggle faults seen
    slfp_lanes_t   rec [4];              // Frames after a sync
    slfp_lanes_t   base_rec [4];         // Frames of the zero run
    logic [15:0]   lfsr_ff = 16'h8E0C;   // Random source
    int            miscompares = 0;      // Mismatch count
    int            cmp_count = 0;        // Compare count

    always #5 sys_clk = ~sys_clk;

    slfp_frame_packer #(.SEQ_FRAMES(SEQ_N)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_in(bus),
        .reg_rdata_ff(rdata), .sync_req(sync_req), .smp_in(smp_in), .lane_frame_ff(lanes),
        .frame_kind_ff(kind));

    slfp_lane_receiver rx (.sys_clk(sys_clk), .rst_n(rst_n), .lane_frame(lanes), .frame_kind(kind),
        .toggle_on(toggle_on), .rx_lanes(rx_lanes), .toggle_errs_ff(tgl_errs));

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic finish_test();
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    // Next random word
    function automatic logic [15:0] rnd();
        lfsr_ff = {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
        return lfsr_ff;
    endfunction : rnd

    // Random valid slot
    function automatic slfp_smp_t rand_smp();
        slfp_smp_t s;
        s = '0;
        s.valid = 1'b1;
        for (int j = 0; j < 60; j++) s.real_smp[j] = 10'(rnd());
        for (int j = 0; j < 16; j++) s.iq[j] = {15'(rnd()), 15'(rnd())};
        return s;
    endfunction : rand_smp

    // Frame contents expected as XOR against a zero frame
    function automatic logic [63:0] exp_frame(input logic ddc, input int n, input int k, input slfp_smp_t s);
        logic [59:0] pl;
        pl = '0;
        if (ddc) pl = {s.iq[k + n], s.iq[k]};
        else for (int j = 0; j < 6; j++) pl[10 * j +: 10] = s.real_smp[6 * k + j];
        return {pl[59:30], 1'b0, ^pl, pl[29:0], 2'b00};
    endfunction : exp_frame

    // One-cycle register write
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr_reg

    // Read and compare data of the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        @(negedge sys_clk);
        check({48'h0, rdata}, {48'h0, e});
    endtask : rd_chk

    // Sync request, sequence checks, then record four data frames
    task automatic do_sync(input logic [63:0] pat);
        int n;
        sync_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sync_req <= 1'b0;
        n = 0;
        while (kind !== SEQ_ALIGN && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (kind === SEQ_ALIGN && n < 40) begin
            for (int k = 0; k < 11; k++) check(lanes[k], pat);
            @(negedge sys_clk);
            n++;
        end
        check(64'(n), 64'(SEQ_N));
        n = 0;
        while (kind === SEQ_PRBS && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check(64'(n), 64'(SEQ_N));
        for (int f = 0; f < 4; f++) begin
            rec[f] = rx_lanes;
            @(negedge sys_clk);
        end
    endtask : do_sync

    // Configure, present samples, sync
    task automatic run(input logic [15:0] cfg, input logic [15:0] mode, input slfp_smp_t s, input logic tg);
        toggle_on <= 1'b0;
        wr_reg(`SLFP_REG_CFG, cfg);
        wr_reg(`SLFP_REG_MODE, mode);
        smp_in <= s;
        repeat (3) @(posedge sys_clk);
        toggle_on <= tg;
        do_sync(`SLFP_ALIGN_RST);
    endtask : run

    // Packed layout of used lanes, lane 10 unchanged in real mode
    task automatic cmp_run(input int n, input logic ddc, input slfp_smp_t s);
        for (int f = 0; f < 4; f++) begin
            for (int k = 0; k < n; k++) begin
                check({rec[f][k][63:2] ^ base_rec[f][k][63:2], 2'b00}, exp_frame(ddc, n, k, s));
            end
            if (!ddc) check({rec[f][10][63:2] ^ base_rec[f][10][63:2], 2'b00}, 64'h0);
        end
    endtask : cmp_run

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial begin
        slfp_smp_t   s;
        logic [15:0] mw [6];
        logic [5:0]  vv;
        logic [5:0]  tv;
        logic [63:0] rev;
        slfp_fstate_t fs [6];
        mw = '{16'h002B, 16'h002B, 16'h000B, 16'h000B, 16'h002D, 16'h002B};
        fs = '{FS_CH12, FS_CH34, FS_CH12, FS_EMPTY, FS_CH34, FS_CH12};
        vv = 6'b110111;
        tv = 6'b100101;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd_chk(`SLFP_REG_CFG, 16'h000F);
        rd_chk(`SLFP_REG_MODE, 16'h0000);
        for (int w = 0; w < 4; w++) rd_chk(`SLFP_REG_ALIGN0 + 8'(w), 16'(`SLFP_ALIGN_RST >> (16 * w)));
        rd_chk(8'h07, 16'h0000);
        s = '0;
        s.valid = 1'b1;
        run(16'h000F, 16'h0000, s, 1'b1);
        base_rec = rec;
        s = rand_smp();
        run(16'h000F, 16'h0000, s, 1'b1);
        cmp_run(10, 1'b0, s);
        s = '1;
        s.fstate = FS_CH12;
        run(16'h000F, 16'h0000, s, 1'b1);
        cmp_run(10, 1'b0, s);
        for (int d = 0; d < 4; d++) begin
            s = rand_smp();
            run(16'h000F, 16'h0001 | 16'(d << 1), s, 1'b1);
            cmp_run(8 >> d, 1'b1, s);
        end
        // Fine channels, four of them, at /16 and /32
        for (int d = 0; d < 2; d++) begin
            s = rand_smp();
            run(16'h000F, (d == 0) ? 16'h0067 : 16'h0029, s, 1'b1);
            cmp_run(4 >> d, 1'b1, s);
        end
        s = rand_smp();
        s.valid = 1'b0;
        s.fstate = FS_EMPTY;
        run(16'h000F, 16'h002B, s, 1'b0);
        for (int f = 0; f < 4; f++) check({63'h0, rec[f][0][33] ^ base_rec[f][0][33]}, 64'h1);
        for (int i = 0; i < 6; i++) begin
            wr_reg(`SLFP_REG_CFG, (i == 2 || i == 3 || i == 5) ? 16'h001F : 16'h000F);
            wr_reg(`SLFP_REG_MODE, mw[i]);
            s.fstate = fs[i];
            s.valid = vv[i];
            smp_in <= s;
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
            check({63'h0, rx_lanes[0][1]}, {63'h0, tv[i]});
        end
        wr_reg(`SLFP_REG_MODE, 16'h0000);
        wr_reg(`SLFP_REG_ALIGN0, 16'h1234);
        rd_chk(`SLFP_REG_ALIGN0, 16'h1234);
        wr_reg(`SLFP_REG_CFG, 16'h0001);
        rev = {<<{64'hACF0_FF00_FFFF_1234}};
        @(posedge sys_clk);
        do_sync(rev);
        check({48'h0, tgl_errs}, 64'h0);
        finish_test();
    end
endmodule : slfp_frame_packer_bench
